//--- logic/expseq_pkg.sv
`default_nettype none
package expseq_pkg;

  // ************************************************************
  // register map (word aligned byte addresses)
  // ************************************************************
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] frames_addr = 8'h04;
  localparam logic [7:0] expose_addr = 8'h08;
  localparam logic [7:0] readout_addr = 8'h0c;
  localparam logic [7:0] interval_addr = 8'h10;
  localparam logic [7:0] status_addr = 8'h14;

  // ************************************************************
  // control fields
  // ************************************************************
  localparam int ctrl_sel_lo = 0;
  localparam int ctrl_sel_hi = 1;
  localparam int ctrl_pol_bit = 2;
  localparam int ctrl_run_bit = 3;
  localparam int ctrl_cap_bit = 4;
  localparam int ctrl_rate_bit = 8;

  localparam logic [1:0] sel_none = 2'h0;
  localparam logic [1:0] sel_standard = 2'h1;
  localparam logic [1:0] sel_pulse_driven_exposure = 2'h2;

  // ************************************************************
  // reset values, counts in core_clk cycles
  // ************************************************************
  localparam logic [31:0] expose_rst = 32'h0000_0064;
  localparam logic [31:0] readout_rst = 32'h0000_00c8;
  localparam logic [31:0] interval_rst = 32'h0000_03e8;
  localparam logic [15:0] frames_rst = 16'h0001;
  localparam logic [31:0] count_one = 32'h0000_0001;
  localparam logic [15:0] frames_one = 16'h0001;
  localparam logic [15:0] frames_zero = 16'h0000;

  typedef enum logic [2:0] {
    expseq_idle,
    expseq_expose,
    expseq_readout,
    expseq_wait_repeat,
    expseq_done
  } expseq_state_e;

  typedef enum logic [1:0] {
    expseq_mode_soft,
    expseq_mode_stream,
    expseq_mode_async,
    expseq_mode_bulb
  } expseq_mode_e;

endpackage
`default_nettype wire

//--- logic/expseq_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface expseq_cfg_if;
  logic [1:0] start_select;
  logic start_edge_select;
  logic run;
  logic capture;
  logic [15:0] frames;
  logic [31:0] expose_len;
  logic [31:0] readout_len;
  logic [31:0] interval_len;
  logic [2:0] state;
  logic strobe;
  logic [15:0] frames_done;
  logic [1:0] mode;

  modport regs (
    output start_select, start_edge_select, run, capture, frames,
    output expose_len, readout_len, interval_len,
    input state, strobe, frames_done, mode
  );
  modport core (
    input start_select, start_edge_select, run, capture, frames,
    input expose_len, readout_len, interval_len,
    output state, strobe, frames_done, mode
  );
endinterface
`default_nettype wire

//--- logic/expseq_ahb_regs.sv
`timescale 1ns/10ps
`default_nettype none
module expseq_ahb_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  expseq_cfg_if.regs cfg
);
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] a;
  logic take;
  logic rate;

  assign take = hsel && hready && htrans[1];
  assign a = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take && hwrite && (hsize == 3'h2);
      wr_addr <= a;
    end
  end

  // capture is a one-cycle pulse; all other fields hold
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg.start_select <= expseq_pkg::sel_none;
      cfg.start_edge_select <= 1'b0;
      cfg.run <= 1'b0;
      cfg.capture <= 1'b0;
      rate <= 1'b0;
      cfg.frames <= expseq_pkg::frames_rst;
      cfg.expose_len <= expseq_pkg::expose_rst;
      cfg.readout_len <= expseq_pkg::readout_rst;
      cfg.interval_len <= expseq_pkg::interval_rst;
    end else begin
      cfg.capture <= 1'b0;
      if (wr_pend) begin
        if (wr_addr == expseq_pkg::ctrl_addr) begin
          cfg.start_select <=
            hwdata[expseq_pkg::ctrl_sel_hi:expseq_pkg::ctrl_sel_lo];
          cfg.start_edge_select <= hwdata[expseq_pkg::ctrl_pol_bit];
          cfg.run <= hwdata[expseq_pkg::ctrl_run_bit];
          cfg.capture <= hwdata[expseq_pkg::ctrl_cap_bit];
          rate <= hwdata[expseq_pkg::ctrl_rate_bit];
        end else if (wr_addr == expseq_pkg::frames_addr) begin
          cfg.frames <= hwdata[15:0];
        end else if (wr_addr == expseq_pkg::expose_addr) begin
          cfg.expose_len <= hwdata;
        end else if (wr_addr == expseq_pkg::readout_addr) begin
          cfg.readout_len <= hwdata;
        end else if (wr_addr == expseq_pkg::interval_addr) begin
          cfg.interval_len <= hwdata;
        end
      end
    end
  end

  // readback registered at the address phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      if (a == expseq_pkg::ctrl_addr) begin
        hrdata <= {23'h000000, rate, 3'h0, 1'b0, cfg.run,
                   cfg.start_edge_select, cfg.start_select};
      end else if (a == expseq_pkg::frames_addr) begin
        hrdata <= {16'h0000, cfg.frames};
      end else if (a == expseq_pkg::expose_addr) begin
        hrdata <= cfg.expose_len;
      end else if (a == expseq_pkg::readout_addr) begin
        hrdata <= cfg.readout_len;
      end else if (a == expseq_pkg::interval_addr) begin
        hrdata <= cfg.interval_len;
      end else if (a == expseq_pkg::status_addr) begin
        hrdata <= {cfg.frames_done, 8'h00, 1'b0, cfg.mode, cfg.strobe,
                   1'b0, cfg.state};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end
endmodule // expseq_ahb_regs
`default_nettype wire

//--- logic/expseq_top.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// (R1) in streaming mode an exposure starts when the trigger goes active.
// (R2) streaming exposures last the set time, then read out, then repeat at the interval untriggered.
// (R3) once streaming has started, further triggers are ignored until stopped.
// (R4) in async mode each trigger starts one timed exposure and one readout.
// (R5) in async mode triggers during readout are ignored.
// (R6) after an async readout the device waits idle for the next trigger.
// (R7) in bulb mode exposure spans the time the trigger is held active.
// (R8) in bulb mode trigger changes during readout are ignored.
// (R9) strobe is high exactly while an exposure is active.
// (R10) with hardware start off, a capture command takes exactly the frame count.
// (R11) standard start with frame count zero or above one selects streaming.
// (R12) standard start with frame count one selects async mode.
// (R13) pulse-driven start selects bulb mode.
// (R14) the polarity setting picks the starting edge and the active level.
// (R15) trigger behaviour does not depend on pixel rate, binning, gain or offset.
// (R16) stopping returns to idle with strobe low; a new start re-arms.
module expseq_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic trigger_in,
  output logic strobe,
  output logic readout_active
);
  expseq_cfg_if cfg ();

  expseq_ahb_regs u_regs (
    .core_clk(core_clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .cfg(cfg)
  );

  // ************************************************************
  // trigger conditioning
  // ************************************************************
  logic trig_level;
  logic trig_prev;
  logic trig_edge;
  logic trig_active;

  // polarity folded in so all later logic sees active-high
  assign trig_level = cfg.start_edge_select ? trigger_in : !trigger_in; // R14

  always_ff @(posedge core_clk) begin
    if (rst) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_level;
    end
  end

  assign trig_edge = trig_level && !trig_prev; // R14
  assign trig_active = trig_level;

  // ************************************************************
  // mode selection
  // ************************************************************
  expseq_pkg::expseq_mode_e sel_mode;
  expseq_pkg::expseq_mode_e mode;

  // pixel rate and other readout settings never enter here
  always_comb begin // R15
    case (cfg.start_select)
      expseq_pkg::sel_standard: begin
        if (cfg.frames == expseq_pkg::frames_one) begin
          sel_mode = expseq_pkg::expseq_mode_async; // R12
        end else begin
          sel_mode = expseq_pkg::expseq_mode_stream; // R11
        end
      end
      expseq_pkg::sel_pulse_driven_exposure: begin
        sel_mode = expseq_pkg::expseq_mode_bulb; // R13
      end
      default: begin
        sel_mode = expseq_pkg::expseq_mode_soft;
      end
    endcase
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  expseq_pkg::expseq_state_e state;
  expseq_pkg::expseq_state_e next_state;
  logic [31:0] cnt;
  logic [31:0] ivl;
  logic [15:0] frames_done;
  logic cnt_end;
  logic ivl_end;
  logic soft_last;

  assign cnt_end = (cnt <= expseq_pkg::count_one);
  assign ivl_end = (ivl <= expseq_pkg::count_one);
  assign soft_last = (frames_done + 16'h0001) >= cfg.frames;

  always_comb begin
    next_state = state;
    case (state)
      expseq_pkg::expseq_idle: begin
        if (mode == expseq_pkg::expseq_mode_soft) begin
          if (cfg.capture && cfg.frames != expseq_pkg::frames_zero) begin
            next_state = expseq_pkg::expseq_expose; // R10
          end
        end else if (cfg.run && trig_edge) begin
          next_state = expseq_pkg::expseq_expose; // R1 R4 R7
        end
      end
      expseq_pkg::expseq_expose: begin
        if (mode == expseq_pkg::expseq_mode_bulb) begin
          if (!trig_active) begin
            next_state = expseq_pkg::expseq_readout; // R7
          end
        end else if (cnt_end) begin
          next_state = expseq_pkg::expseq_readout; // R2 R4
        end
      end
      expseq_pkg::expseq_readout: begin
        // trigger not looked at while reading out
        if (cnt_end) begin // R5 R8
          case (mode)
            expseq_pkg::expseq_mode_stream: begin
              next_state = ivl_end ? expseq_pkg::expseq_expose
                                   : expseq_pkg::expseq_wait_repeat; // R2
            end
            expseq_pkg::expseq_mode_soft: begin
              next_state = soft_last ? expseq_pkg::expseq_idle
                                     : expseq_pkg::expseq_expose; // R10
            end
            default: begin
              next_state = expseq_pkg::expseq_idle; // R6
            end
          endcase
        end
      end
      expseq_pkg::expseq_wait_repeat: begin
        if (ivl_end) begin
          next_state = expseq_pkg::expseq_expose; // R2 R3
        end
      end
      default: begin
        next_state = expseq_pkg::expseq_idle;
      end
    endcase
    // stop abandons everything, software capture excepted
    if (!cfg.run && mode != expseq_pkg::expseq_mode_soft) begin
      next_state = expseq_pkg::expseq_idle; // R16
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= expseq_pkg::expseq_idle;
    end else begin
      state <= next_state;
    end
  end

  // mode latched in idle so reprogramming mid-frame cannot corrupt it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode <= expseq_pkg::expseq_mode_soft;
    end else if (state == expseq_pkg::expseq_idle) begin
      mode <= sel_mode;
    end
  end

  // phase counter: loaded on entry to expose and readout
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= expseq_pkg::count_one;
    end else if (next_state == expseq_pkg::expseq_expose &&
                 state != expseq_pkg::expseq_expose) begin
      cnt <= cfg.expose_len;
    end else if (next_state == expseq_pkg::expseq_readout &&
                 state != expseq_pkg::expseq_readout) begin
      cnt <= cfg.readout_len;
    end else if (!cnt_end) begin
      cnt <= cnt - expseq_pkg::count_one;
    end
  end

  // repeat interval measured from each exposure start
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ivl <= expseq_pkg::count_one;
    end else if (next_state == expseq_pkg::expseq_expose &&
                 state != expseq_pkg::expseq_expose) begin
      ivl <= cfg.interval_len; // R2
    end else if (next_state == expseq_pkg::expseq_idle) begin
      ivl <= expseq_pkg::count_one; // R16
    end else if (!ivl_end) begin
      ivl <= ivl - expseq_pkg::count_one;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      frames_done <= 16'h0000;
    end else if (state == expseq_pkg::expseq_idle &&
                 next_state == expseq_pkg::expseq_expose) begin
      frames_done <= 16'h0000;
    end else if (state == expseq_pkg::expseq_readout && cnt_end) begin
      frames_done <= frames_done + 16'h0001;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strobe <= 1'b0;
      readout_active <= 1'b0;
    end else begin
      strobe <= (next_state == expseq_pkg::expseq_expose); // R9
      readout_active <= (next_state == expseq_pkg::expseq_readout);
    end
  end

  assign cfg.state = state;
  assign cfg.strobe = strobe;
  assign cfg.frames_done = frames_done;
  assign cfg.mode = mode;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_rd_enter;
    state == expseq_pkg::expseq_readout &&
      $past(state) != expseq_pkg::expseq_readout;
  endsequence

  sequence s_exp_enter;
    state == expseq_pkg::expseq_expose &&
      $past(state) != expseq_pkg::expseq_expose;
  endsequence

  a_strobe_tracks: assert property (@(posedge core_clk) disable iff (rst)
    strobe == (state == expseq_pkg::expseq_expose)) // R9
    else $error("strobe does not follow exposure");
  a_stream_sel: assert property (@(posedge core_clk) disable iff (rst)
    (cfg.start_select == expseq_pkg::sel_standard &&
     cfg.frames != expseq_pkg::frames_one)
    |-> sel_mode == expseq_pkg::expseq_mode_stream) // R11
    else $error("streaming mode not selected");
  a_async_sel: assert property (@(posedge core_clk) disable iff (rst)
    (cfg.start_select == expseq_pkg::sel_standard &&
     cfg.frames == expseq_pkg::frames_one)
    |-> sel_mode == expseq_pkg::expseq_mode_async) // R12
    else $error("async mode not selected");
  a_bulb_sel: assert property (@(posedge core_clk) disable iff (rst)
    cfg.start_select == expseq_pkg::sel_pulse_driven_exposure
    |-> sel_mode == expseq_pkg::expseq_mode_bulb) // R13
    else $error("bulb mode not selected");
  a_trig_start: assert property (@(posedge core_clk) disable iff (rst)
    (state == expseq_pkg::expseq_idle && cfg.run && trig_edge &&
     mode != expseq_pkg::expseq_mode_soft)
    |=> state == expseq_pkg::expseq_expose && strobe) // R1
    else $error("trigger did not start exposure");
  a_rd_no_trig: assert property (@(posedge core_clk) disable iff (rst)
    (state == expseq_pkg::expseq_readout && !cnt_end && cfg.run)
    |=> state == expseq_pkg::expseq_readout) // R5
    else $error("readout cut short");
  a_bulb_end: assert property (@(posedge core_clk) disable iff (rst)
    (state == expseq_pkg::expseq_expose && cfg.run &&
     mode == expseq_pkg::expseq_mode_bulb && !trig_active)
    |=> s_rd_enter) // R7
    else $error("bulb exposure not ended by trigger");
  a_async_idle: assert property (@(posedge core_clk) disable iff (rst)
    (state == expseq_pkg::expseq_readout && cnt_end &&
     mode == expseq_pkg::expseq_mode_async)
    |=> state == expseq_pkg::expseq_idle) // R6
    else $error("async did not return to idle");
  a_stop_idle: assert property (@(posedge core_clk) disable iff (rst)
    (!cfg.run && mode != expseq_pkg::expseq_mode_soft)
    |=> state == expseq_pkg::expseq_idle && !strobe) // R16
    else $error("stop did not idle");
  a_edge_pol: assert property (@(posedge core_clk) disable iff (rst)
    trig_edge |-> trig_active &&
      (trigger_in == cfg.start_edge_select)) // R14
    else $error("edge polarity wrong");
  a_readout_flag: assert property (@(posedge core_clk) disable iff (rst)
    readout_active == (state == expseq_pkg::expseq_readout)) // R2 R4
    else $error("readout flag does not follow readout");
  a_repeat_start: assert property (@(posedge core_clk) disable iff (rst)
    (state == expseq_pkg::expseq_wait_repeat && ivl_end && cfg.run)
    |=> s_exp_enter ##0 strobe) // R2
    else $error("repeat interval did not restart exposure");
  a_stream_hold: assert property (@(posedge core_clk) disable iff (rst)
    (state != expseq_pkg::expseq_idle && cfg.run &&
     mode == expseq_pkg::expseq_mode_stream)
    |=> state != expseq_pkg::expseq_idle) // R3
    else $error("streaming stopped without a stop");
  a_exp_hold: assert property (@(posedge core_clk) disable iff (rst)
    (state == expseq_pkg::expseq_expose && !cnt_end &&
     mode != expseq_pkg::expseq_mode_bulb &&
     (cfg.run || mode == expseq_pkg::expseq_mode_soft))
    |=> state == expseq_pkg::expseq_expose && strobe) // R2 R4
    else $error("timed exposure ended early");
  a_bulb_hold: assert property (@(posedge core_clk) disable iff (rst)
    (state == expseq_pkg::expseq_expose && cfg.run &&
     mode == expseq_pkg::expseq_mode_bulb && trig_active)
    |=> state == expseq_pkg::expseq_expose && strobe) // R7
    else $error("bulb exposure ended while trigger held");
  a_bulb_rd_end: assert property (@(posedge core_clk) disable iff (rst)
    (state == expseq_pkg::expseq_readout && cnt_end &&
     mode == expseq_pkg::expseq_mode_bulb)
    |=> state == expseq_pkg::expseq_idle) // R8
    else $error("bulb readout did not return to idle");
  a_async_no_retrig: assert property (@(posedge core_clk) disable iff (rst)
    (state == expseq_pkg::expseq_readout && trig_edge && cfg.run &&
     mode == expseq_pkg::expseq_mode_async)
    |=> !strobe) // R5
    else $error("trigger during readout started exposure");
  a_cap_start: assert property (@(posedge core_clk) disable iff (rst)
    (state == expseq_pkg::expseq_idle && cfg.capture &&
     mode == expseq_pkg::expseq_mode_soft &&
     cfg.frames != expseq_pkg::frames_zero)
    |=> s_exp_enter) // R10
    else $error("capture did not start exposure");
  a_soft_count: assert property (@(posedge core_clk) disable iff (rst)
    (state == expseq_pkg::expseq_readout && cnt_end && soft_last &&
     mode == expseq_pkg::expseq_mode_soft)
    |=> state == expseq_pkg::expseq_idle && frames_done == cfg.frames) // R10
    else $error("software capture frame count wrong");
endmodule // expseq_top
`default_nettype wire

//--- test/expseq_trig_src.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// external trigger source model
// ************************************************************
module expseq_trig_src (
  input wire logic core_clk,
  input wire logic active_high,
  output logic trigger_in
);
  logic asserted = 1'b0;

  // rests at the inactive level between pulses
  assign trigger_in = asserted ? active_high : ~active_high;

  // one pulse per wanted frame; width sets the bulb exposure
  task automatic pulse(input int width);
    @(posedge core_clk);
    asserted <= 1'b1;
    repeat (width) @(posedge core_clk);
    asserted <= 1'b0;
  endtask
endmodule // expseq_trig_src
`default_nettype wire

//--- test/exposure_trigger_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module exposure_trigger_sequencer_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic trigger_in;
  logic strobe;
  logic readout_active;
  logic pol = 1'b0;
  logic strobe_q = 1'b0;
  logic [31:0] rd;
  int num_errors = 0;
  int n_checks = 0;
  int n_rise = 0;
  int n_hi = 0;
  int n_rd = 0;

  always #5 core_clk = ~core_clk;

  expseq_top uut (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .trigger_in(trigger_in), .strobe(strobe),
    .readout_active(readout_active)
  );

  expseq_trig_src src (
    .core_clk(core_clk), .active_high(pol), .trigger_in(trigger_in)
  );

  // ************************************************************
  // activity counters
  // ************************************************************
  // sampled mid-cycle so a check made at a rising edge sees every count
  always @(negedge core_clk) begin
    strobe_q <= strobe;
    if (strobe === 1'b1) n_hi++;
    if (strobe === 1'b1 && strobe_q !== 1'b1) n_rise++;
    if (readout_active === 1'b1) n_rd++;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp,
                         input logic [31:0] mask);
    ahb(a, 1'b0, 32'h0);
    chk(rd & mask, exp);
  endtask

  task automatic clr();
    n_rise = 0;
    n_hi = 0;
    n_rd = 0;
  endtask

  task automatic counts(input int r, input int h, input int d);
    chk(32'(n_rise), 32'(r));
    chk(32'(n_hi), 32'(h));
    chk(32'(n_rd), 32'(d));
  endtask

  task automatic ctrl(input logic [1:0] sel, input logic run,
                      input logic rate);
    wr(expseq_pkg::ctrl_addr, {23'h0, rate, 4'h0, run, pol, sel});
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset_values();
    chk_reg(expseq_pkg::frames_addr, 32'h1, 32'hffff);
    chk_reg(expseq_pkg::expose_addr, expseq_pkg::expose_rst, '1);
    chk_reg(expseq_pkg::readout_addr, expseq_pkg::readout_rst, '1);
    chk_reg(expseq_pkg::interval_addr, expseq_pkg::interval_rst, '1);
    chk_reg(expseq_pkg::status_addr, 32'h0, '1);
    chk_reg(8'h18, 32'h0, '1);
    chk(32'(hresp), 32'h0);
  endtask

  // byte-sized or deselected writes must leave the registers alone
  task automatic t_refused();
    hsize <= 3'h0;
    wr(expseq_pkg::frames_addr, 32'h7);
    hsize <= 3'h2;
    hsel <= 1'b0;
    wr(expseq_pkg::expose_addr, 32'h9);
    hsel <= 1'b1;
    chk_reg(expseq_pkg::frames_addr, 32'h1, '1);
    chk_reg(expseq_pkg::expose_addr, expseq_pkg::expose_rst, '1);
    chk(32'(hresp), 32'h0);
  endtask

  // one timed frame per pulse; a pulse in readout is dropped
  task automatic t_async(input logic p);
    ctrl(expseq_pkg::sel_standard, 1'b0, 1'b0);
    pol <= p;
    wr(expseq_pkg::frames_addr, 32'h1);
    ctrl(expseq_pkg::sel_standard, 1'b1, 1'b0);
    clr();
    src.pulse(2);
    repeat (4) @(posedge core_clk);
    src.pulse(2);
    repeat (40) @(posedge core_clk);
    counts(1, 3, 4);
    chk_reg(expseq_pkg::status_addr, 32'h0001_0040, '1);
    ctrl(expseq_pkg::sel_standard, 1'b0, 1'b0);
  endtask

  // start-to-start repeat of 20 cycles, later pulses ignored, then stop
  task automatic t_stream(input logic [15:0] frames, input logic rate);
    wr(expseq_pkg::frames_addr, {16'h0, frames});
    ctrl(expseq_pkg::sel_standard, 1'b1, rate);
    clr();
    src.pulse(2);
    repeat (30) @(posedge core_clk);
    src.pulse(2);
    repeat (33) @(posedge core_clk);
    counts(4, 12, 16);
    ctrl(expseq_pkg::sel_standard, 1'b0, rate);
    repeat (2) @(posedge core_clk);
    chk(32'(strobe), 32'h0);
    chk_reg(expseq_pkg::status_addr, 32'h20, 32'h7f);
    chk_reg(expseq_pkg::ctrl_addr, {23'h0, rate, 4'h0, 1'b0, pol,
            expseq_pkg::sel_standard}, '1);
    clr();
    repeat (30) @(posedge core_clk);
    counts(0, 0, 0);
  endtask

  task automatic t_bulb();
    ctrl(expseq_pkg::sel_pulse_driven_exposure, 1'b1, 1'b0);
    clr();
    src.pulse(10);
    repeat (2) @(posedge core_clk);
    src.pulse(1);
    repeat (30) @(posedge core_clk);
    counts(1, 10, 4);
    chk_reg(expseq_pkg::status_addr, 32'h0001_0060, '1);
    ctrl(expseq_pkg::sel_pulse_driven_exposure, 1'b0, 1'b0);
  endtask

  // trigger line stays quiet; capture alone takes the frame count
  task automatic t_soft();
    wr(expseq_pkg::frames_addr, 32'h3);
    ctrl(expseq_pkg::sel_none, 1'b0, 1'b0);
    clr();
    wr(expseq_pkg::ctrl_addr, 32'h10);
    repeat (60) @(posedge core_clk);
    counts(3, 9, 12);
    chk_reg(expseq_pkg::status_addr, 32'h0003_0000, '1);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_values();
    t_refused();
    wr(expseq_pkg::expose_addr, 32'h3);
    wr(expseq_pkg::readout_addr, 32'h4);
    wr(expseq_pkg::interval_addr, 32'h14);
    t_async(1'b0);
    t_async(1'b1);
    t_stream(16'h0000, 1'b0);
    t_stream(16'h0002, 1'b1);
    t_bulb();
    t_soft();
    test_done();
  end
endmodule // exposure_trigger_sequencer_tb_top
`default_nettype wire
